//--- stpm_monitor.sv
// Supply and thermal protection monitor: converter sequencing, faults,
// warnings, latched flags, interrupt, APB registers.
// Assumes converter results arrive synchronous to pclk with a valid strobe.
`timescale 1ns/100ps
module stpm_monitor
  import stpm_pkg::*;
#(
  parameter int RETRY_CYCLES = STPM_RETRY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_data,
  input  wire logic        temp_valid,
  input  wire logic [11:0] temp_data,
  output logic             conv_start,
  output logic [1:0]       conv_channel,
  output logic             shutdown,
  output logic             interrupt_out_n,
  output logic             tx_voltage_valid,
  output logic [23:0]      tx_voltage_word
);
  localparam int RCW = $clog2(RETRY_CYCLES + 1);
  // Channel codes: 0 main battery pin, 1 sense pin, 2 stage supply
  localparam logic [1:0] CH_BAT  = 2'h0;
  localparam logic [1:0] CH_SNS  = 2'h1;
  localparam logic [1:0] CH_STAGE_SUPPLY = 2'h2;

  logic [31:0] ctrl;
  logic [1:0]  ov_limit_internal_boost;
  logic [1:0]  ov_limit_external_supply;
  logic [11:0] battery_voltage_result;
  logic [11:0] stage_supply_result;
  logic [11:0] junction_temp_result;
  logic [STPM_NFLAG-1:0] flags;
  logic [STPM_NFLAG-1:0] mask;
  logic [23:0] warn_min;
  logic [23:0] warn_step;
  logic [11:0] uv_bat;
  logic [11:0] uv_bat2;
  logic [11:0] uv_stage_supply;
  logic [11:0] ot_limit;
  logic [1:0]  slot_cnt;
  logic        busy;
  logic [RCW-1:0] retry_cnt;
  logic        retry_fire;
  logic [STPM_NFLAG-1:0] events;
  logic [11:0] ov_limit;
  logic [1:0]  bmode;
  logic        wr_en;
  logic        rd_en;
  logic        wr_mode;

  assign bmode   = ctrl[STPM_BMODE_LSB +: 2];
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign wr_mode = wr_en && (paddr == STPM_CTRL_OFS);
  assign pready  = 1'b1;

  // Limit selection follows supply mode
  always_comb begin
    logic [1:0] sel;
    sel = ctrl[STPM_BOOST_BIT] ? ov_limit_internal_boost : ov_limit_external_supply;
    case (sel)
      2'h0:    ov_limit = STPM_OV_135;
      2'h1:    ov_limit = STPM_OV_140;
      2'h2:    ov_limit = STPM_OV_150;
      default: ov_limit = STPM_OV_160;
    endcase
  end

  // Fault events from the latest results; warnings are decoded separately below
  always_comb begin
    events = '0;
    if (conv_valid && conv_channel != CH_STAGE_SUPPLY) begin
      events[STPM_F_BUV]  = (bmode != 2'h2) && (conv_data < uv_bat);
      events[STPM_F_B2UV] = (bmode == 2'h2) && (conv_data < uv_bat2);
    end
    if (conv_valid && conv_channel == CH_STAGE_SUPPLY) begin
      events[STPM_F_POV] = !ctrl[STPM_OVDIS_BIT] && (conv_data > ov_limit);
      events[STPM_F_PUV] = conv_data < uv_stage_supply;
    end
    if (temp_valid) begin
      events[STPM_F_OT] = temp_data > ot_limit;
    end
  end

  // Warning thresholds min + k*step, width kept at 24 bits
  for (genvar k = 0; k < 4; k++) begin : g_warn
    logic [23:0] thr;
    assign thr = warn_min + 24'(k) * warn_step;
  end
  logic [3:0] warn_hit;
  for (genvar k = 0; k < 4; k++) begin : g_whit
    assign warn_hit[k] = temp_valid && ({12'h000, temp_data} >= g_warn[k].thr);
  end

  // Converter sequencing: favoured input gets three slots per other
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy         <= 1'b0;
      slot_cnt     <= '0;
      conv_channel <= CH_BAT;
      conv_start   <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (!busy) begin
        logic fav_bat;
        fav_bat = !ctrl[STPM_PRIO_BIT];
        busy       <= 1'b1;
        conv_start <= 1'b1;
        if ((slot_cnt == STPM_FAVOUR_SLOTS) ^ !fav_bat) begin
          conv_channel <= CH_STAGE_SUPPLY;
        end else begin
          conv_channel <= (bmode == 2'h0) ? CH_BAT : CH_SNS;
        end
        slot_cnt <= (slot_cnt == STPM_FAVOUR_SLOTS) ? 2'h0 : slot_cnt + 2'h1;
      end else if (conv_valid) begin
        busy <= 1'b0;
      end
    end
  end

  // Result registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_voltage_result <= '0;
      stage_supply_result    <= '0;
      junction_temp_result   <= '0;
      tx_voltage_valid       <= 1'b0;
      tx_voltage_word        <= '0;
    end else begin
      tx_voltage_valid <= 1'b0;
      if (conv_valid && conv_channel == CH_STAGE_SUPPLY) stage_supply_result <= conv_data;
      if (conv_valid && conv_channel != CH_STAGE_SUPPLY) battery_voltage_result <= conv_data;
      if (temp_valid) junction_temp_result <= temp_data;
      if (conv_valid && ctrl[STPM_STREAM_BIT]) begin
        tx_voltage_valid <= 1'b1;
        tx_voltage_word  <= {8'h00, 2'h0, conv_channel, conv_data};
      end
    end
  end

  // Latched flags: set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      logic [STPM_NFLAG-1:0] clr;
      clr = (wr_en && paddr == STPM_FLAG_OFS) ? pwdata[STPM_NFLAG-1:0] : '0;
      flags <= (flags & ~clr) | events | {warn_hit, 5'h00};
    end
  end

  // Shutdown: faults force it, host write or retry timer lifts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown <= 1'b0;
    end else if (|events[STPM_F_OT:0]) begin
      shutdown <= 1'b1;
    end else if (wr_mode && pwdata[STPM_MODE_LSB +: 2] != 2'h2) begin
      shutdown <= 1'b0;
    end else if (retry_fire) begin
      shutdown <= 1'b0;
    end
  end

  // Retry timer runs only while shut down by over-temperature
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_cnt <= '0;
    end else if (shutdown && flags[STPM_F_OT] && ctrl[STPM_RETRY_BIT]) begin
      retry_cnt <= retry_fire ? '0 : retry_cnt + RCW'(1);
    end else begin
      retry_cnt <= '0;
    end
  end
  assign retry_fire = (retry_cnt == RCW'(RETRY_CYCLES - 1)) && !events[STPM_F_OT];

  // Interrupt output registered; low while unmasked flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) interrupt_out_n <= 1'b1;
    else interrupt_out_n <= ~|(flags & mask);
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                     <= STPM_CTRL_RST;
      ov_limit_internal_boost  <= STPM_OVI_RST;
      ov_limit_external_supply <= STPM_OVE_RST;
      mask     <= '0;
      warn_min <= STPM_WMIN_RST;
      warn_step <= STPM_WSTEP_RST;
      uv_bat   <= STPM_UVB_RST;
      uv_bat2  <= STPM_UV2_RST;
      uv_stage_supply  <= STPM_UVP_RST;
      ot_limit <= STPM_OT_RST;
    end else if (wr_en) begin
      case (paddr)
        STPM_CTRL_OFS:  ctrl <= {23'h0, pwdata[8:0]};
        STPM_OVLIM_OFS: begin
          ov_limit_internal_boost  <= pwdata[1:0];
          ov_limit_external_supply <= pwdata[3:2];
        end
        STPM_MASK_OFS:  mask <= pwdata[STPM_NFLAG-1:0];
        STPM_WMIN_OFS:  warn_min <= pwdata[23:0];
        STPM_WSTEP_OFS: warn_step <= pwdata[23:0];
        STPM_UVLIM_OFS: begin
          uv_bat  <= pwdata[11:0];
          uv_stage_supply <= pwdata[27:16];
        end
        STPM_OTLIM_OFS: begin
          ot_limit <= pwdata[11:0];
          uv_bat2  <= pwdata[27:16];
        end
        default: ;
      endcase
    end
  end

  // Read mux, registered data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          STPM_CTRL_OFS:  prdata <= ctrl;
          STPM_OVLIM_OFS: prdata <= {28'h0, ov_limit_external_supply, ov_limit_internal_boost};
          STPM_VBAT_OFS:  prdata <= {20'h0, battery_voltage_result};
          STPM_STAGE_SUPPLY_OFS:  prdata <= {20'h0, stage_supply_result};
          STPM_TEMP_OFS:  prdata <= {20'h0, junction_temp_result};
          STPM_FLAG_OFS:  prdata <= {23'h0, flags};
          STPM_MASK_OFS:  prdata <= {23'h0, mask};
          STPM_WMIN_OFS:  prdata <= {8'h00, warn_min};
          STPM_WSTEP_OFS: prdata <= {8'h00, warn_step};
          STPM_UVLIM_OFS: prdata <= {4'h0, uv_stage_supply, 4'h0, uv_bat};
          STPM_OTLIM_OFS: prdata <= {4'h0, uv_bat2, 4'h0, ot_limit};
          default:        prdata <= '0;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;

  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ov_shutdown_a: assert property (events[STPM_F_POV] |=> shutdown && flags[STPM_F_POV])
    else $error("over-voltage did not shut down");
  ov_disable_a: assert property (ctrl[STPM_OVDIS_BIT] |-> !events[STPM_F_POV])
    else $error("over-voltage seen while disabled");
  ot_flag_a: assert property (events[STPM_F_OT] |=> flags[STPM_F_OT] && shutdown)
    else $error("over-temperature not latched");
  irq_mask_a: assert property ((flags & mask) != '0 |=> !interrupt_out_n)
    else $error("unmasked flag without interrupt");
  irq_idle_a: assert property ((flags & mask) == '0 |=> interrupt_out_n)
    else $error("interrupt without unmasked flag");
  flag_hold_a: assert property (flags[0] && !(wr_en && paddr == STPM_FLAG_OFS) |=> flags[0])
    else $error("flag lost without clear");
  bat_result_a: assert property (conv_valid && conv_channel != CH_STAGE_SUPPLY |=> battery_voltage_result == $past(conv_data))
    else $error("battery result not stored");
  temp_result_a: assert property (temp_valid |=> junction_temp_result == $past(temp_data))
    else $error("temperature result not stored");
  src_sel_a: assert property (conv_start && conv_channel != CH_STAGE_SUPPLY |-> conv_channel == ((bmode == 2'h0) ? CH_BAT : CH_SNS) || $changed(ctrl))
    else $error("wrong battery source");
  stay_down_a: assert property (shutdown && !wr_mode && !retry_fire |=> shutdown)
    else $error("left shutdown unasked");
  ov_cov_c: cover property (events[STPM_F_POV] ##1 shutdown);
  ot_retry_c: cover property (retry_fire);
  warn_c: cover property (warn_hit[3]);
endmodule

//--- stpm_pkg.sv
// Package for the supply and thermal protection monitor.
// Assumes a 10 MHz APB clock; used by stpm_monitor and the bench.
package stpm_pkg;
  // Register byte offsets
  localparam logic [7:0] STPM_CTRL_OFS   = 8'h00;
  localparam logic [7:0] STPM_OVLIM_OFS  = 8'h04;
  localparam logic [7:0] STPM_VBAT_OFS   = 8'h08;
  localparam logic [7:0] STPM_STAGE_SUPPLY_OFS   = 8'h0C;
  localparam logic [7:0] STPM_TEMP_OFS   = 8'h10;
  localparam logic [7:0] STPM_FLAG_OFS   = 8'h14;
  localparam logic [7:0] STPM_MASK_OFS   = 8'h18;
  localparam logic [7:0] STPM_WMIN_OFS   = 8'h1C;
  localparam logic [7:0] STPM_WSTEP_OFS  = 8'h20;
  localparam logic [7:0] STPM_UVLIM_OFS  = 8'h24;
  localparam logic [7:0] STPM_OTLIM_OFS  = 8'h28;
  // Control field positions
  localparam int STPM_MODE_LSB   = 0;  // 2-bit operating mode
  localparam int STPM_BMODE_LSB  = 2;  // 2-bit battery mode
  localparam int STPM_PRIO_BIT   = 4;  // sampling priority
  localparam int STPM_OVDIS_BIT  = 5;  // ov_detect_disable
  localparam int STPM_RETRY_BIT  = 6;  // overtemp_retry_enable
  localparam int STPM_BOOST_BIT  = 7;  // boost_enable_bit
  localparam int STPM_STREAM_BIT = 8;  // stream voltages out
  // Reset values
  localparam logic [31:0] STPM_CTRL_RST  = 32'h0000_0080;
  localparam logic [1:0]  STPM_OVI_RST   = 2'h3;
  localparam logic [1:0]  STPM_OVE_RST   = 2'h1;
  localparam logic [23:0] STPM_WMIN_RST  = 24'h00_0069;  // 105 C
  localparam logic [23:0] STPM_WSTEP_RST = 24'h00_000A;  // 10 C
  localparam logic [11:0] STPM_UVB_RST   = 12'h0_0FA;    // 2.5 V in 10 mV
  localparam logic [11:0] STPM_UV2_RST   = 12'h0_1F4;
  localparam logic [11:0] STPM_UVP_RST   = 12'h0_0FA;
  localparam logic [11:0] STPM_OT_RST    = 12'h0_0A0;    // 160 C
  // Over-voltage limits in 10 mV: 13.5 14 15 16 V
  localparam logic [11:0] STPM_OV_135 = 12'h5_46;
  localparam logic [11:0] STPM_OV_140 = 12'h5_78;
  localparam logic [11:0] STPM_OV_150 = 12'h5_DC;
  localparam logic [11:0] STPM_OV_160 = 12'h6_40;
  // Sampling: favoured input gets this many slots per one of the other
  localparam logic [1:0] STPM_FAVOUR_SLOTS = 2'h3;
  // Retry wait
  localparam real STPM_RETRY_S   = 1.5;
  localparam real STPM_CLK_HZ    = 10.0e6;
  localparam int  STPM_RETRY_CYC = int'(STPM_RETRY_S * STPM_CLK_HZ);
  // Flag bit positions
  localparam int STPM_F_BUV  = 0;
  localparam int STPM_F_POV  = 1;
  localparam int STPM_F_PUV  = 2;
  localparam int STPM_F_B2UV = 3;
  localparam int STPM_F_OT   = 4;
  localparam int STPM_F_W0   = 5;  // warnings 5..8
  localparam int STPM_NFLAG  = 9;
  typedef enum logic [1:0] {STPM_MODE_ACTIVE, STPM_MODE_MUTE, STPM_MODE_SHDN, STPM_MODE_AUTO} stpm_mode_t;
endpackage

//--- stpm_conv_model.sv
// Converter and temperature sensor front end facing the monitor.
// Assumes the bench sets bat_v, sup_v and tmp_v; one clock, pclk.
`timescale 1ns/100ps
module stpm_conv_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic [1:0]  conv_channel,
  input  wire logic [11:0] bat_v,
  input  wire logic [11:0] sup_v,
  input  wire logic [11:0] tmp_v,
  output logic             conv_valid = 1'b0,
  output logic [11:0]      conv_data = 12'h000,
  output logic             temp_valid = 1'b0,
  output logic [11:0]      temp_data = 12'h000
);
  int          n_bat, n_sup, n_conv, wt, tc;
  bit          busy;
  logic [1:0]  ch, bat_ch;
  logic [13:0] ld;
  // One conversion at a time, latency 1 to 4 cycles so no fixed timing is assumed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy = 0;
      conv_valid <= 1'b0;
      temp_valid <= 1'b0;
    end else begin
      tc++;
      temp_valid <= (tc % 8 == 0);
      temp_data <= (tc % 8 == 0) ? tmp_v : ~temp_data;  // Garbled between strobes
      conv_valid <= 1'b0;
      if (busy && --wt == 0) begin
        busy = 0;
        n_conv++;
        conv_valid <= 1'b1;
        conv_data <= (ch == 2'd2) ? sup_v : bat_v;
        ld <= {ch, (ch == 2'd2) ? sup_v : bat_v};
      end else begin
        conv_data <= ~conv_data;
      end
      // Count starts per channel; a start while busy is ignored
      if (conv_start && !busy) begin
        busy = 1;
        ch = conv_channel;
        wt = 1 + n_conv % 4;
        if (conv_channel == 2'd2) n_sup++;
        else begin
          n_bat++;
          bat_ch <= conv_channel;
        end
      end
    end
  end
endmodule

//--- test_supply_thermal_protection_monitor.sv
// Self-checking bench for the supply and thermal protection monitor.
// Assumes stpm_pkg, stpm_monitor and stpm_conv_model are compiled first.
`timescale 1ns/100ps
module test_supply_thermal_protection_monitor;
  import stpm_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, rs = 32'd56365;
  logic        pready, pslverr, conv_valid, temp_valid, conv_start, shutdown, irq_n, txv;
  logic [11:0] conv_data, temp_data, bat_v = 12'h200, sup_v = 12'h1F4, tmp_v = 12'h028;
  logic [1:0]  conv_channel;
  logic [23:0] txw;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, mask = 0, ctrl = 'h80, ovl = 7;
  int          wmin = 105, wstep = 10, b, s;
  int          ovt[4] = '{1350, 1400, 1500, 1600};
  logic [7:0]  ra[5] = '{STPM_CTRL_OFS, STPM_OVLIM_OFS, STPM_WMIN_OFS, STPM_WSTEP_OFS, 8'h3C};
  logic [31:0] rv[5] = '{32'h0000_0080, 32'h0000_0007, 32'h0000_0069, 32'h0000_000A, 0};

  stpm_monitor #(.RETRY_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
    .temp_valid(temp_valid), .temp_data(temp_data), .conv_start(conv_start),
    .conv_channel(conv_channel), .shutdown(shutdown), .interrupt_out_n(irq_n),
    .tx_voltage_valid(txv), .tx_voltage_word(txw));
  stpm_conv_model model_u (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_channel(conv_channel), .bat_v(bat_v), .sup_v(sup_v), .tmp_v(tmp_v),
    .conv_valid(conv_valid), .conv_data(conv_data), .temp_valid(temp_valid),
    .temp_data(temp_data));

  // Free-running clock, 100 ns period
  always #50 pclk = ~pclk;
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      results();
    end
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Expected flag word from the current supply and temperature
  function automatic int ef(int pv, int t);
    int r = 0;
    int l = ctrl[7] ? ovl[1:0] : ovl[3:2];
    if (!ctrl[5] && pv > ovt[l]) r |= 2;
    if (t > int'(STPM_OT_RST)) r |= 16;
    for (int i = 0; i < 4; i++) if (t >= wmin + i * wstep) r |= 32 << i;
    return r;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // APB transfer: setup, then access held until pready at a rising edge
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(q, e);
    chk(pslverr, 0);
  endtask
  task automatic wc(input int v);
    ctrl = v;
    apb(1, STPM_CTRL_OFS, v);
  endtask
  task automatic wm(input int v);
    mask = v;
    apb(1, STPM_MASK_OFS, v);
  endtask
  task automatic settle(input int n);
    int c;
    c = model_u.n_conv;
    for (int i = 0; i < 400 && model_u.n_conv < c + n; i++) @(posedge pclk);
  endtask
  task automatic step(input int pv, input int t);
    int e;
    @(posedge pclk);
    sup_v <= 12'(pv);
    tmp_v <= 12'(t);
    settle(8);
    e = ef(pv, t);
    rd(STPM_FLAG_OFS, e);
    chk(shutdown, |e[4:0]);
    chk(irq_n, (e & mask) == 0);
  endtask
  // Remove the cause, clear flags, then restart from the host side
  task automatic clr();
    logic sd;
    @(posedge pclk);
    sup_v <= 12'h1F4;
    tmp_v <= 12'h028;
    settle(8);
    sd = shutdown;
    apb(1, STPM_FLAG_OFS, 32'h0000_01FF);
    chk(shutdown, sd);
    wc(ctrl);
    settle(2);
    chk(shutdown, 0);
    rd(STPM_FLAG_OFS, 0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(1, 8'h3C, 32'hFFFF_FFFF);
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("test reset values done");
    for (int m = 0; m < 3; m++) begin
      wc('h80 | (m << 2));
      settle(12);
      chk(model_u.bat_ch, m == 0 ? 0 : 1);
    end
    wc('h80);
    b = model_u.n_bat;
    s = model_u.n_sup;
    settle(16);
    chk(model_u.n_bat - b > model_u.n_sup - s, 1);
    wc('h90);
    b = model_u.n_bat;
    s = model_u.n_sup;
    settle(16);
    chk(model_u.n_sup - s > model_u.n_bat - b, 1);
    wc('h80);
    $display("test sampling done");
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      bat_v <= 12'h200 | 12'(xs() & 32'h0000_00FF);
      tmp_v <= 12'h020 | 12'(xs() & 32'h0000_001F);
      settle(8);
      rd(STPM_VBAT_OFS, bat_v);
      rd(STPM_STAGE_SUPPLY_OFS, sup_v);
      rd(STPM_TEMP_OFS, tmp_v);
    end
    wc('h180);
    for (int i = 0; i < 200 && txv !== 1'b1; i++) @(posedge pclk);
    chk(txw, {10'h0, model_u.ld});
    wc('h80);
    $display("test results done");
    for (int k = 0; k < 4; k++) begin
      ovl = 4 | k;
      wm(k[0] ? 2 : 0);
      apb(1, STPM_OVLIM_OFS, ovl);
      step(ovt[k] - 20, 40);
      step(ovt[k] + 20, 40);
      clr();
    end
    wc('h00);
    step(1450, 40);
    clr();
    wc('hA0);
    step(1700, 40);
    clr();
    wc('h80);
    $display("test over-voltage done");
    wm(16);
    step(500, 170);
    clr();
    wc('hC0);
    @(posedge pclk);
    tmp_v <= 12'h0AA;
    for (int i = 0; i < 200 && shutdown !== 1'b1; i++) @(posedge pclk);
    chk(shutdown, 1);
    @(posedge pclk);
    tmp_v <= 12'h028;
    for (int i = 0; i < 200 && shutdown !== 1'b0; i++) @(posedge pclk);
    chk(shutdown, 0);
    wc('h80);
    clr();
    $display("test over-temperature done");
    wm('h40);
    step(500, 118);
    clr();
    wm('h100);
    step(500, 130);
    clr();
    wmin = 50;
    wstep = 20;
    apb(1, STPM_WMIN_OFS, wmin);
    apb(1, STPM_WSTEP_OFS, wstep);
    step(500, 95);
    clr();
    $display("test warnings done");
    results();
  end
endmodule
